/* asri_pkg.sv */
// Shared constants and state types for the converter serial readout link.
package asri_pkg;
    localparam int WORD_BITS          = 32;
    localparam int CLK_PERIOD_NS      = 4;
    localparam int SCK_DIV            = 8;
    localparam int SCK_HALF_CYC       = SCK_DIV / 2;
    localparam int TEST_DELAY_INT_NS  = 23000;
    localparam int TEST_DELAY_INT_CYC = (TEST_DELAY_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TEST_DELAY_EXT_X10 = 36;
    localparam int EXT_OSC_PERIOD_NS  = 1000;
    localparam int HOST_HALF_CYC      = 8;
    localparam int HOST_SETTLE_CYC    = 8;
    localparam int FIFO_DEPTH         = 2;

    typedef enum logic [1:0] {
        ASRI_CONVERT = 2'b00,
        ASRI_SLEEP   = 2'b01,
        ASRI_OUTPUT  = 2'b10
    } asri_dev_state_t;

    typedef enum logic [2:0] {
        ASRI_H_IDLE = 3'b000,
        ASRI_H_PREP = 3'b001,
        ASRI_H_POLL = 3'b010,
        ASRI_H_EXT  = 3'b011,
        ASRI_H_INT  = 3'b100,
        ASRI_H_END  = 3'b101
    } asri_host_state_t;
endpackage

/* asri_link_if.sv */
// Three-wire link between converter and host, resolving the shared pin levels.
`timescale 1ns/1ps
interface asri_link_if;
    logic csN;
    logic hostSckOut;
    logic hostSckOeN;
    logic devSckOut;
    logic devSckOeN;
    logic devPullUpEn;
    logic devSdoOut;
    logic devSdoOeN;
    logic sckLine;
    logic sdoLine;

    // An undriven clock pin floats high only while the weak pull-up is on.
    assign sckLine = !devSckOeN  ? devSckOut  :
                     !hostSckOeN ? hostSckOut : devPullUpEn;
    // An undriven data pin reads high, as with a bus pull-up.
    assign sdoLine = !devSdoOeN ? devSdoOut : 1'b1;

    modport dev (
        input  csN,
        input  sckLine,
        output devSckOut,
        output devSckOeN,
        output devPullUpEn,
        output devSdoOut,
        output devSdoOeN
    );

    modport host (
        output csN,
        output hostSckOut,
        output hostSckOeN,
        input  sckLine,
        input  sdoLine
    );
endinterface

/* asri_device.sv */
// Converter end: clock mode selection, status flag, result shifter and conversion control.
// Overview of operation
// R01: Chip-select fall with clock low selects external.
// R02: Data output floats while chip select high.
// R03: Chip select low shows busy flag.
// R04: Finished conversion enters sleep on its own.
// R05: Sleep holds result until clock rise.
// R06: Data changes on falling clock edges.
// R07: External modes restart conversion on falling 32.
// R08: Host may poll flag or float output.
// R09: External chip-select rise in output aborts, converts.
// R10: Two-wire mode fixed at power-on reset end.
// R11: Result loaded when busy flag falls.
// R12: Clock high at chip-select fall selects internal.
// R13: Internal mode: chip-select fall drives clock low.
// R14: Internal mode starts output after status delay.
// R15: Chip select high before rise keeps sleep.
// R16: Internal output ends after 32 rises, restarts.
// R17: Internal chip-select rise in output aborts, converts.
// R18: Pull-up off while clock pin is low.
// R19: Chip-select rise after status test restores pull-up.
// R20: Host keeps clock high or fits pull-up.
// R21: Internal clock is conversion clock divided by eight.
// R22: Result leaves most significant bit first.
// R23: Chip select and clock synchronised before edges.
`timescale 1ns/1ps
module asri_device
    import asri_pkg::*;
#(
    parameter int TEST_DELAY_INT = TEST_DELAY_INT_CYC,
    parameter int EXT_OSC_NS     = EXT_OSC_PERIOD_NS
)
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    asri_link_if.dev                  link,
    input  wire logic                 oscExtSel,
    input  wire logic [WORD_BITS-1:0] resultData,
    input  wire logic                 resultValid,
    output logic                      convStart,
    output logic                      convBusy
);
    localparam int TEST_DELAY_EXT = (TEST_DELAY_EXT_X10 * EXT_OSC_NS + 10 * CLK_PERIOD_NS - 1)
                                    / (10 * CLK_PERIOD_NS);
    localparam logic [15:0] DLY_INT = 16'(TEST_DELAY_INT);
    localparam logic [15:0] DLY_EXT = 16'((TEST_DELAY_EXT < 1) ? 1 : TEST_DELAY_EXT);
    localparam logic [5:0]  LAST_RISE = 6'(WORD_BITS);
    localparam logic [1:0]  HALF_END  = 2'(SCK_HALF_CYC - 1);

    asri_dev_state_t        state_r;
    asri_dev_state_t        state_nxt;
    logic [1:0]             csSync_r;
    logic [1:0]             sckSync_r;
    logic                   csDly_r;
    logic                   sckDly_r;
    logic                   intMode_r;
    logic                   intMode_nxt;
    logic [1:0]             porCnt_r;
    logic                   csActive_r;
    logic [WORD_BITS-1:0]   shift_r;
    logic [WORD_BITS-1:0]   shift_nxt;
    logic [5:0]             riseCnt_r;
    logic [5:0]             riseCnt_nxt;
    logic [1:0]             divCnt_r;
    logic [1:0]             divCnt_nxt;
    logic                   sckOut_r;
    logic                   sckOut_nxt;
    logic [15:0]            delayCnt_r;
    logic [15:0]            delayCnt_nxt;
    logic                   pullUp_r;
    logic                   pullUp_nxt;
    logic                   start_r;
    logic                   start_nxt;
    logic                   sdo_r;

    wire csHigh    = csSync_r[1];
    wire sckLevel  = sckSync_r[1];
    wire csFall    = csDly_r & ~csHigh;
    wire csRise    = ~csDly_r & csHigh;
    wire sckRise   = ~sckDly_r & sckLevel;
    wire sckFall   = sckDly_r & ~sckLevel;
    // Power-on mode is taken only once the clock synchroniser holds the real pin level.
    wire porPend   = (porCnt_r == 2'h1);
    // The clock pin is driven only after this select cycle's mode has been latched.
    wire csActNxt  = ~csHigh & (csActive_r | csFall);
    wire [15:0] delayTarget = oscExtSel ? DLY_EXT : DLY_INT;
    wire halfDone  = (divCnt_r == HALF_END);
    wire sdoNxt    = (state_r == ASRI_CONVERT) ? 1'b1 : shift_r[WORD_BITS-1]; // R03 R22

    // Synchronisers feed only their second stage; edges come from stage two.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            csSync_r  <= 2'h3;
            sckSync_r <= 2'h3;
            csDly_r   <= 1'b1;
            sckDly_r  <= 1'b1;
        end
        else
        begin
            csSync_r  <= {csSync_r[0], link.csN}; // R23
            sckSync_r <= {sckSync_r[0], link.sckLine}; // R23
            csDly_r   <= csSync_r[1];
            sckDly_r  <= sckSync_r[1];
        end
    end

    always_comb
    begin
        state_nxt    = state_r;
        intMode_nxt  = intMode_r;
        shift_nxt    = shift_r;
        riseCnt_nxt  = riseCnt_r;
        divCnt_nxt   = divCnt_r;
        sckOut_nxt   = sckOut_r;
        delayCnt_nxt = delayCnt_r;
        pullUp_nxt   = pullUp_r;
        start_nxt    = 1'b0;
        if (porPend)
        begin
            intMode_nxt = sckLevel; // R10
            start_nxt   = 1'b1;
        end
        else if (csFall)
        begin
            intMode_nxt = sckLevel; // R01 R12
            sckOut_nxt  = 1'b0; // R13
        end
        if (csRise && state_r == ASRI_SLEEP)
            pullUp_nxt = 1'b1; // R19
        else if (sckFall)
            pullUp_nxt = 1'b0; // R18
        else if (sckRise)
            pullUp_nxt = 1'b1;
        case (state_r)
            ASRI_CONVERT:
            begin
                if (resultValid)
                begin
                    shift_nxt = {1'b0, resultData[WORD_BITS-2:0]}; // R11
                    state_nxt = ASRI_SLEEP; // R04
                end
            end
            ASRI_SLEEP:
            begin
                if (!intMode_r)
                begin
                    if (!csHigh && sckRise)
                    begin
                        state_nxt   = ASRI_OUTPUT; // R05
                        riseCnt_nxt = 6'h01;
                    end
                end
                else if (csHigh || csFall)
                    delayCnt_nxt = 16'h0000; // R15
                else if (delayCnt_r + 16'h0001 >= delayTarget)
                begin
                    state_nxt    = ASRI_OUTPUT; // R14
                    sckOut_nxt   = 1'b1;
                    riseCnt_nxt  = 6'h01;
                    divCnt_nxt   = 2'h0;
                    delayCnt_nxt = 16'h0000;
                end
                else
                    delayCnt_nxt = delayCnt_r + 16'h0001;
            end
            ASRI_OUTPUT:
            begin
                if (csRise)
                begin
                    state_nxt  = ASRI_CONVERT; // R09 R17
                    start_nxt  = 1'b1;
                    sckOut_nxt = 1'b1;
                end
                else if (intMode_r)
                begin
                    divCnt_nxt = divCnt_r + 2'h1; // R21
                    if (halfDone && !sckOut_r)
                    begin
                        sckOut_nxt  = 1'b1;
                        riseCnt_nxt = riseCnt_r + 6'h01;
                    end
                    else if (halfDone && riseCnt_r == LAST_RISE)
                    begin
                        state_nxt = ASRI_CONVERT; // R16
                        start_nxt = 1'b1;
                    end
                    else if (halfDone)
                    begin
                        sckOut_nxt = 1'b0;
                        shift_nxt  = {shift_r[WORD_BITS-2:0], 1'b1}; // R06 R22
                    end
                end
                else
                begin
                    if (sckRise)
                        riseCnt_nxt = riseCnt_r + 6'h01;
                    if (sckFall && riseCnt_r == LAST_RISE)
                    begin
                        state_nxt = ASRI_CONVERT; // R07
                        start_nxt = 1'b1;
                    end
                    else if (sckFall)
                        shift_nxt = {shift_r[WORD_BITS-2:0], 1'b1}; // R06 R22
                end
            end
            default:
                state_nxt = ASRI_CONVERT;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r    <= ASRI_CONVERT;
            intMode_r  <= 1'b1;
            porCnt_r   <= 2'h3;
            csActive_r <= 1'b0;
            shift_r    <= '0;
            riseCnt_r  <= 6'h00;
            divCnt_r   <= 2'h0;
            sckOut_r   <= 1'b1;
            delayCnt_r <= 16'h0000;
            pullUp_r   <= 1'b1;
            start_r    <= 1'b0;
            sdo_r      <= 1'b1;
        end
        else
        begin
            state_r    <= state_nxt;
            intMode_r  <= intMode_nxt;
            porCnt_r   <= (porCnt_r != 2'h0) ? porCnt_r - 2'h1 : 2'h0;
            csActive_r <= csActNxt;
            shift_r    <= shift_nxt;
            riseCnt_r  <= riseCnt_nxt;
            divCnt_r   <= divCnt_nxt;
            sckOut_r   <= sckOut_nxt;
            delayCnt_r <= delayCnt_nxt;
            pullUp_r   <= pullUp_nxt;
            start_r    <= start_nxt;
            sdo_r      <= sdoNxt;
        end
    end

    assign link.devSdoOut   = sdo_r;
    assign link.devSdoOeN   = csHigh; // R02
    assign link.devSckOut   = sckOut_r;
    assign link.devSckOeN   = ~(intMode_r & csActive_r & ~csHigh); // R13
    assign link.devPullUpEn = pullUp_r;
    assign convStart        = start_r;
    assign convBusy         = (state_r == ASRI_CONVERT);
endmodule

/* asri_host.sv */
// Host end: selects the clock mode, polls the busy flag and reads words into a small buffer.
`timescale 1ns/1ps
module asri_host
    import asri_pkg::*;
#(
    parameter int HALF_CYC   = HOST_HALF_CYC,
    parameter int SETTLE_CYC = HOST_SETTLE_CYC
)
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    asri_link_if.host                 link,
    input  wire logic                 useIntClock,
    input  wire logic                 readReq,
    output logic [WORD_BITS-1:0]      rdData,
    output logic                      rdValid,
    input  wire logic                 rdReady,
    output logic                      busy
);
    localparam logic [7:0] HALF_END   = 8'(HALF_CYC - 1);
    localparam logic [7:0] SETTLE_END = 8'(SETTLE_CYC - 1);
    localparam logic [5:0] LAST_BIT   = 6'(WORD_BITS);

    asri_host_state_t       state_r;
    logic [7:0]             cnt_r;
    logic [5:0]             bitCnt_r;
    logic                   csN_r;
    logic                   sckOut_r;
    logic                   sckOeN_r;
    logic                   sckPrev_r;
    logic [WORD_BITS-1:0]   capt_r;
    logic [WORD_BITS-1:0]   mem [FIFO_DEPTH];
    logic                   wrPtr_r;
    logic                   rdPtr_r;
    logic [1:0]             count_r;

    wire cntDone = (cnt_r == HALF_END);
    wire settled = (cnt_r == SETTLE_END);
    wire devRise = ~sckPrev_r & link.sckLine;
    wire hasRoom = (count_r < 2'(FIFO_DEPTH));
    wire push    = (state_r == ASRI_H_END);
    wire pop     = rdValid & rdReady;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r   <= ASRI_H_IDLE;
            cnt_r     <= 8'h00;
            bitCnt_r  <= 6'h00;
            csN_r     <= 1'b1;
            sckOut_r  <= 1'b0;
            sckOeN_r  <= 1'b0;
            sckPrev_r <= 1'b1;
            capt_r    <= '0;
        end
        else
        begin
            sckPrev_r <= link.sckLine;
            cnt_r     <= cnt_r + 8'h01;
            case (state_r)
                ASRI_H_IDLE:
                begin
                    csN_r <= 1'b1;
                    cnt_r <= 8'h00;
                    if (readReq && hasRoom)
                        state_r <= ASRI_H_PREP;
                end
                ASRI_H_PREP:
                begin
                    sckOut_r <= 1'b0;
                    sckOeN_r <= useIntClock; // R01 R10 R12
                    if (settled)
                    begin
                        csN_r    <= 1'b0;
                        cnt_r    <= 8'h00;
                        bitCnt_r <= 6'h00;
                        state_r  <= useIntClock ? ASRI_H_INT : ASRI_H_POLL;
                    end
                end
                ASRI_H_POLL:
                begin
                    if (!settled)
                        cnt_r <= cnt_r + 8'h01;
                    else if (link.sdoLine)
                        cnt_r <= cnt_r; // R03 R08
                    else
                    begin
                        cnt_r   <= 8'h00;
                        state_r <= ASRI_H_EXT;
                    end
                end
                ASRI_H_EXT:
                begin
                    if (cntDone)
                    begin
                        cnt_r    <= 8'h00;
                        sckOut_r <= ~sckOut_r;
                        if (!sckOut_r)
                        begin
                            capt_r   <= {capt_r[WORD_BITS-2:0], link.sdoLine}; // R06
                            bitCnt_r <= bitCnt_r + 6'h01;
                        end
                        else if (bitCnt_r == LAST_BIT)
                            state_r <= ASRI_H_END; // R07
                    end
                end
                ASRI_H_INT:
                begin
                    if (devRise)
                    begin
                        capt_r   <= {capt_r[WORD_BITS-2:0], link.sdoLine}; // R06
                        bitCnt_r <= bitCnt_r + 6'h01;
                    end
                    if (bitCnt_r == LAST_BIT && link.sckLine)
                        state_r <= ASRI_H_END; // R16 R20
                end
                ASRI_H_END:
                begin
                    csN_r   <= 1'b1; // R08
                    state_r <= ASRI_H_IDLE;
                end
                default:
                    state_r <= ASRI_H_IDLE;
            endcase
        end
    end

    // Room is checked before a read starts, so a stalled reader stops new reads.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wrPtr_r <= 1'b0;
            rdPtr_r <= 1'b0;
            count_r <= 2'h0;
        end
        else
        begin
            if (push)
                wrPtr_r <= ~wrPtr_r;
            if (pop)
                rdPtr_r <= ~rdPtr_r;
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wrPtr_r] <= capt_r;
    end

    assign rdData          = mem[rdPtr_r];
    assign rdValid         = (count_r != 2'h0);
    assign busy            = (state_r != ASRI_H_IDLE);
    assign link.csN        = csN_r;
    assign link.hostSckOut = sckOut_r;
    assign link.hostSckOeN = sckOeN_r;
endmodule

/* asri_link_monitor.sv */
// Concurrent checks on the converter link pins and the conversion control outputs.
`timescale 1ns/1ps
module asri_link_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic csN,
    input wire logic sckLine,
    input wire logic devSckOeN,
    input wire logic devPullUpEn,
    input wire logic devSdoOut,
    input wire logic devSdoOeN,
    input wire logic convStart,
    input wire logic convBusy
);
    default clocking mcb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_SDO_FLOAT: assert property (csN [*5] |-> devSdoOeN)
        else $error("data pin driven while chip select high");
    AST_SDO_DRIVE: assert property (!csN [*5] |-> !devSdoOeN)
        else $error("data pin not driven while chip select low");
    AST_BUSY_FLAG: assert property (convBusy && $past(convBusy, 6) && !devSdoOeN |-> devSdoOut)
        else $error("status flag low during conversion");
    AST_SLEEP_FLAG: assert property ($fell(convBusy) && !csN && $past(csN, 8) == 1'b0
        |-> ##[0:4] !devSdoOut)
        else $error("status flag did not drop on entering sleep");
    AST_PULLUP_OFF: assert property (!sckLine [*8] |-> !devPullUpEn)
        else $error("clock pull-up left on while clock pin low");
    AST_EXT_NO_DRIVE: assert property ($fell(csN) && !sckLine |-> ##1 devSckOeN [*8])
        else $error("clock pin driven after external mode selection");
    AST_SDO_STABLE_HIGH: assert property (!csN && $past(csN, 8) == 1'b0 && sckLine
        && $past(sckLine) |-> $stable(devSdoOut))
        else $error("data changed while clock high");
    AST_START_CONV: assert property (convStart |-> ##[0:1] convBusy ##1 !convStart)
        else $error("conversion start not followed by conversion state");
endmodule

/* asri_tb_top.sv */
// Bench joining host and converter ends, plus a converter whose pins the bench drives.
`timescale 1ns/1ps
module asri_conv_model
    import asri_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 start,
    output logic                      valid,
    output logic [WORD_BITS-1:0]      data
);
    logic [7:0] cnt_r;
    // A conversion lasts forty cycles and yields a fresh word each time.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_r <= 8'h00;
            valid <= 1'b0;
            data  <= 32'h9ABC_DEF1;
        end
        else
        begin
            valid <= (cnt_r == 8'h01);
            cnt_r <= start ? 8'h28 : (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
            if (start)
                data <= data + 32'h1357_9BDF;
        end
    end
endmodule

module asri_tb_top
    import asri_pkg::*;
;
    localparam int DLY_INT = 20;
    localparam int OSC_NS  = 100;
    localparam int DLY_EXT = (TEST_DELAY_EXT_X10 * OSC_NS / 10 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic useIntClock = 1'b0;
    logic readReq = 1'b0;
    logic rdReady = 1'b0;
    logic oscSel2 = 1'b0;
    logic rdValid, busy, convStart, convBusy, resValid, start2, busy2, valid2;
    logic [WORD_BITS-1:0] rdData, resData, data2;
    logic [WORD_BITS-1:0] expQ [$];
    logic [WORD_BITS-1:0] expQ2 [$];
    int err_total = 0;
    int total_checks = 0;

    always #2 clk = ~clk;

    asri_link_if link ();
    asri_link_if link2 ();
    asri_device #(.TEST_DELAY_INT(DLY_INT), .EXT_OSC_NS(OSC_NS)) asri_device_inst (
        .clk(clk), .rst_n(rst_n), .link(link), .oscExtSel(1'b0), .resultData(resData),
        .resultValid(resValid), .convStart(convStart), .convBusy(convBusy));
    asri_host asri_host_inst (
        .clk(clk), .rst_n(rst_n), .link(link), .useIntClock(useIntClock), .readReq(readReq),
        .rdData(rdData), .rdValid(rdValid), .rdReady(rdReady), .busy(busy));
    asri_conv_model asri_conv_model_inst (
        .clk(clk), .rst_n(rst_n), .start(convStart), .valid(resValid), .data(resData));
    asri_device #(.TEST_DELAY_INT(DLY_INT), .EXT_OSC_NS(OSC_NS)) asri_device_inst_b (
        .clk(clk), .rst_n(rst_n), .link(link2), .oscExtSel(oscSel2), .resultData(data2),
        .resultValid(valid2), .convStart(start2), .convBusy(busy2));
    asri_conv_model asri_conv_model_inst_b (
        .clk(clk), .rst_n(rst_n), .start(start2), .valid(valid2), .data(data2));
    asri_link_monitor asri_link_monitor_inst (
        .clk(clk), .rst_n(rst_n), .csN(link.csN), .sckLine(link.sckLine),
        .devSckOeN(link.devSckOeN), .devPullUpEn(link.devPullUpEn), .devSdoOut(link.devSdoOut),
        .devSdoOeN(link.devSdoOeN), .convStart(convStart), .convBusy(convBusy));

    // The word read out carries a zero status flag in place of its top bit.
    always @(posedge clk)
    begin
        if (resValid === 1'b1)
            expQ.push_back({1'b0, resData[30:0]});
        if (valid2 === 1'b1)
            expQ2.push_back({1'b0, data2[30:0]});
    end

    task automatic cmpWord(input string name, input logic [WORD_BITS-1:0] exp,
                           input logic [WORD_BITS-1:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmpBit(input string name, input logic exp, input logic got);
        cmpWord(name, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic drain(input int n);
        int w;
        rdReady <= 1'b1;
        repeat (n)
        begin
            w = 0;
            @(posedge clk);
            while (rdValid !== 1'b1 && w < 3000)
            begin
                @(posedge clk);
                w++;
            end
            cmpBit("rdValid", 1'b1, rdValid);
            cmpWord("rdData", expQ.pop_front(), rdData);
        end
        rdReady <= 1'b0;
    endtask

    task automatic waitIdle2();
        int w;
        w = 0;
        while (busy2 !== 1'b0 && w < 500)
        begin
            @(posedge clk);
            w++;
        end
        cmpBit("busy2", 1'b0, busy2);
    endtask

    // Internal clock read by the bench; fewer than 32 rises ends in an abort.
    task automatic readInt(input int dly, input int n);
        logic [WORD_BITS-1:0] word;
        logic prev;
        int rises;
        int w;
        word = '0;
        rises = 0;
        w = 0;
        waitIdle2();
        link2.csN <= 1'b0;
        @(posedge clk);
        prev = link2.sckLine;
        while (rises < n && w < 2000)
        begin
            @(posedge clk);
            w++;
            if (link2.sckLine === 1'b1 && prev === 1'b0)
            begin
                if (rises == 0)
                    cmpBit("delay", 1'b1, w >= dly && w <= dly + 12);
                word = {word[30:0], link2.sdoLine};
                rises++;
            end
            prev = link2.sckLine;
        end
        cmpBit("rises", 1'b1, rises == n);
        if (n == 32)
        begin
            cmpWord("word2", expQ2.pop_front(), word);
            repeat (16) @(posedge clk);
            cmpBit("sck2", 1'b1, link2.sckLine);
            cmpBit("busy2", 1'b1, busy2);
            link2.csN <= 1'b1;
        end
        else
        begin
            link2.csN <= 1'b1;
            repeat (8) @(posedge clk);
            cmpBit("busy2", 1'b1, busy2);
            void'(expQ2.pop_front());
        end
    endtask

    task automatic statTest(input logic sckExp);
        waitIdle2();
        link2.csN <= 1'b0;
        repeat (8) @(posedge clk);
        cmpBit("sck2", sckExp, link2.sckLine);
        cmpBit("sdo2", 1'b0, link2.sdoLine);
        link2.csN <= 1'b1;
        repeat (8) @(posedge clk);
        cmpBit("busy2", 1'b0, busy2);
        cmpBit("pullUp2", ~sckExp, link2.devPullUpEn);
        cmpBit("sdoOe2", 1'b1, link2.devSdoOeN);
    endtask

    initial
    begin
        link2.csN <= 1'b1;
        link2.hostSckOut <= 1'b0;
        link2.hostSckOeN <= 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        readReq <= 1'b1;
        repeat (2500) @(posedge clk);
        cmpBit("busy", 1'b0, busy);
        cmpBit("rdValid", 1'b1, rdValid);
        readReq <= 1'b0;
        drain(2);
        @(posedge clk);
        cmpBit("rdValid", 1'b0, rdValid);
        readReq <= 1'b1;
        drain(2);
        readReq <= 1'b0;
        statTest(1'b0);
        readInt(DLY_INT, 32);
        oscSel2 <= 1'b1;
        readInt(DLY_EXT, 32);
        readInt(DLY_EXT, 5);
        // Bench drives the clock low so the next selection picks external mode.
        link2.hostSckOeN <= 1'b0;
        statTest(1'b0);
        link2.csN <= 1'b0;
        repeat (8) @(posedge clk);
        cmpBit("sckOe2", 1'b1, link2.devSckOeN);
        repeat (3)
        begin
            link2.hostSckOut <= 1'b1;
            repeat (8) @(posedge clk);
            link2.hostSckOut <= 1'b0;
            repeat (8) @(posedge clk);
        end
        link2.csN <= 1'b1;
        repeat (8) @(posedge clk);
        cmpBit("busy2", 1'b1, busy2);
        test_done();
    end

    initial
    begin
        repeat (30000) @(posedge clk);
        err_total++;
        $display("Error watchdog expected finish seen timeout");
        test_done();
    end
endmodule
